// File: common/host_pins_pkg.sv
// Constants shared by the host pin block and its synchroniser.
// Assumes a 250 MHz system clock and a host-driven serial clock.
`default_nettype none

package host_pins_pkg;

    localparam int SYS_CLK_PERIOD_NS = 4;
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;

    // Bit positions in the synchronised pin vector
    localparam int PIN_SYNC_WIDTH = 5;
    localparam int PIN_IFACE_SEL = 0;
    localparam int PIN_ADDR0_SEL_N = 1;
    localparam int PIN_ADDR1 = 2;
    localparam int PIN_RESET_N = 3;
    localparam int PIN_OUT_DIS = 4;
    // Idle levels of the pins: select high, chip select high, reset high
    localparam logic [4:0] PIN_SYNC_RESET = 5'h0b;

    localparam int STATUS_WIDTH = 5;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic TOGGLE_RESET = 1'b0;

    typedef enum logic [1:0] {
        MODE_I2C,
        MODE_SPI4,
        MODE_SPI3
    } link_mode_t;

endpackage

`default_nettype wire

// File: src/host_serial_select_and_status_pins.sv
// Host link pin multiplexing, device reset, output disable and status pins.
// Assumes core logic on sys_clk supplies lock and input-clock status, and
// that the host drives serial_clk only inside SPI frames.
`default_nettype none

// What this block does
// R01 - The serial link runs as I2C when the interface select pin is 1 and as SPI when it is 0.
// R02 - The data pin is bidirectional in I2C and 3-wire SPI, and input only in 4-wire SPI.
// R03 - The second shared pin is address bit 1 in I2C and the device's serial output in 4-wire SPI.
// R04 - The host supplies the serial clock in both modes and the device never makes it.
// R05 - The third shared pin is address bit 0 in I2C and the active-low chip select in SPI.
// R06 - The interrupt output goes low whenever the device status has changed.
// R07 - The active-low reset pin resets all internal logic and registers to their defaults, except the pin synchroniser and the SPI shift registers.
// R08 - Clock outputs stay disabled for as long as reset lasts.
// R09 - Clock outputs are disabled while the output disable pin is high and enabled while low.
// R10 - The lock-lost output is high while the PLL is locked and low while out of lock.
// R11 - Each of inputs 0 to 2 has an active-low signal-lost output, low while no clock is seen.
// R12 - Input 3 likewise has an active-low signal-lost output, low while no clock is seen.
module host_serial_select_and_status_pins
    import host_pins_pkg::*;
(
    // System clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Host serial clock
    input wire logic serial_clk,
    // Interface select and shared pins
    input wire logic interface_select,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe_n,
    input wire logic addr1_or_serial_out_pin_in,
    output logic addr1_or_serial_out_pin_out,
    output logic addr1_or_serial_out_pin_oe_n,
    input wire logic addr0_or_select_n_pin,
    // Control pins
    input wire logic device_reset_n,
    input wire logic output_disable,
    // Status pins
    output logic status_change_irq_n,
    output logic lock_lost_n,
    output logic input0_signal_lost_n,
    output logic input1_signal_lost_n,
    output logic input2_signal_lost_n,
    output logic input3_signal_lost_n,
    // Core side: configuration and status
    input wire logic spi_three_wire,
    input wire logic i2c_data_drive_low,
    input wire logic jitter_cleaning_pll_locked,
    input wire logic [3:0] input_clock_present,
    input wire logic status_irq_clear,
    // Core side: state, received data and reply byte
    output logic i2c_mode,
    output logic [1:0] i2c_addr_bits,
    output logic device_in_reset,
    output logic clock_outputs_enable,
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    input wire logic [7:0] tx_byte
);

    // Pin synchronisation
    logic [PIN_SYNC_WIDTH-1:0] pins_raw, pins_sync;
    logic core_rst;

    assign pins_raw[PIN_IFACE_SEL] = interface_select;
    assign pins_raw[PIN_ADDR0_SEL_N] = addr0_or_select_n_pin;
    assign pins_raw[PIN_ADDR1] = addr1_or_serial_out_pin_in;
    assign pins_raw[PIN_RESET_N] = device_reset_n;
    assign pins_raw[PIN_OUT_DIS] = output_disable;

    pin_sync3 #(
        .WIDTH(PIN_SYNC_WIDTH),
        .RESET_VALUE(PIN_SYNC_RESET)
    ) u_pin_sync (
        .clk(sys_clk),
        .rst(reset),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // A low reset pin holds everything but the synchroniser and the SPI shift registers in reset
    assign core_rst = reset | ~pins_sync[PIN_RESET_N]; // [R07]

    // Link domain: only SPI frames are shifted here
    logic frame_clear, link_rst;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic first_byte_done_reg, first_byte_done_next;
    logic [7:0] rx_hold_reg, rx_hold_next;
    logic byte_toggle_reg, byte_toggle_next;
    logic [7:0] tx_hold_reg;

    // Chip select high or I2C mode ends the frame without needing a clock edge
    assign frame_clear = addr0_or_select_n_pin | interface_select; // [R05] [R01]
    assign link_rst = reset | ~device_reset_n; // [R07]

    always_comb begin
        bit_cnt_next = bit_cnt_reg + 3'h1;
        rx_shift_next = {rx_shift_reg[6:0], data_pin_in};
        tx_shift_next = {tx_shift_reg[6:0], 1'b0};
        first_byte_done_next = first_byte_done_reg;
        if (bit_cnt_reg == LAST_BIT) begin
            // Reply byte is reloaded at every byte boundary
            tx_shift_next = tx_hold_reg;
            first_byte_done_next = 1'b1;
        end
    end

    // Serial clock comes only from the host [R04]
    always_ff @(posedge serial_clk or posedge frame_clear) begin
        if (frame_clear) begin
            bit_cnt_reg <= FIRST_BIT;
            rx_shift_reg <= BYTE_RESET;
            tx_shift_reg <= BYTE_RESET;
            first_byte_done_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            rx_shift_reg <= rx_shift_next;
            tx_shift_reg <= tx_shift_next;
            first_byte_done_reg <= first_byte_done_next;
        end
    end

    // Toggle and hold survive frame end, so the system side sees no false event
    always_comb begin
        rx_hold_next = rx_hold_reg;
        byte_toggle_next = byte_toggle_reg;
        if (bit_cnt_reg == LAST_BIT) begin
            rx_hold_next = {rx_shift_reg[6:0], data_pin_in};
            byte_toggle_next = ~byte_toggle_reg;
        end
    end

    always_ff @(posedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            rx_hold_reg <= BYTE_RESET;
            byte_toggle_reg <= TOGGLE_RESET;
        end else if (!frame_clear) begin
            rx_hold_reg <= rx_hold_next;
            byte_toggle_reg <= byte_toggle_next;
        end
    end

    // System side of the byte crossing
    logic byte_toggle_sync, byte_toggle_seen_reg, byte_toggle_seen_next;
    logic [7:0] rx_byte_reg, rx_byte_next, tx_hold_next;
    logic rx_valid_reg, rx_valid_next;
    logic byte_event;

    pin_sync3 #(
        .WIDTH(1),
        .RESET_VALUE(TOGGLE_RESET)
    ) u_toggle_sync (
        .clk(sys_clk),
        .rst(link_rst),
        .async_in(byte_toggle_reg),
        .sync_out(byte_toggle_sync)
    );

    assign byte_event = byte_toggle_sync ^ byte_toggle_seen_reg;

    // Hold is stable long before the toggle passes the synchroniser; the
    // new reply is taken a full byte before the link reloads it.
    always_comb begin
        byte_toggle_seen_next = byte_toggle_sync;
        rx_byte_next = rx_byte_reg;
        tx_hold_next = tx_hold_reg;
        rx_valid_next = byte_event;
        if (byte_event) begin
            rx_byte_next = rx_hold_reg;
            tx_hold_next = tx_byte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            byte_toggle_seen_reg <= TOGGLE_RESET;
            rx_byte_reg <= BYTE_RESET;
            tx_hold_reg <= BYTE_RESET;
            rx_valid_reg <= 1'b0;
        end else begin
            byte_toggle_seen_reg <= byte_toggle_seen_next;
            rx_byte_reg <= rx_byte_next;
            tx_hold_reg <= tx_hold_next;
            rx_valid_reg <= rx_valid_next;
        end
    end

    assign rx_byte = rx_byte_reg;
    assign rx_byte_valid = rx_valid_reg;

    // Mode, address and control state
    link_mode_t mode_reg, mode_next;
    logic [1:0] addr_reg, addr_next;
    logic clk_en_reg, clk_en_next;
    logic in_reset_reg;

    always_comb begin
        if (pins_sync[PIN_IFACE_SEL]) begin
            mode_next = MODE_I2C; // [R01]
        end else if (spi_three_wire) begin
            mode_next = MODE_SPI3; // [R01]
        end else begin
            mode_next = MODE_SPI4; // [R01]
        end
        addr_next = addr_reg;
        if (mode_next == MODE_I2C) begin
            // Address straps only mean something in I2C mode
            addr_next = {pins_sync[PIN_ADDR1], pins_sync[PIN_ADDR0_SEL_N]}; // [R03] [R05]
        end
        clk_en_next = ~pins_sync[PIN_OUT_DIS]; // [R09]
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            mode_reg <= MODE_I2C;
            addr_reg <= 2'h0;
            clk_en_reg <= 1'b0; // [R08]
        end else begin
            mode_reg <= mode_next;
            addr_reg <= addr_next;
            clk_en_reg <= clk_en_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            in_reset_reg <= 1'b1;
        end else begin
            in_reset_reg <= core_rst; // [R07]
        end
    end

    assign i2c_mode = (mode_reg == MODE_I2C);
    assign i2c_addr_bits = addr_reg;
    assign device_in_reset = in_reset_reg;
    assign clock_outputs_enable = clk_en_reg & ~in_reset_reg; // [R08] [R09]

    // Shared pin drivers; enables are low while driving
    logic spi_selected;
    assign spi_selected = ~addr0_or_select_n_pin; // [R05]

    always_comb begin
        data_pin_out = 1'b0;
        data_pin_oe_n = 1'b1;
        addr1_or_serial_out_pin_out = 1'b0;
        addr1_or_serial_out_pin_oe_n = 1'b1;
        unique case (mode_reg)
            MODE_I2C: begin
                // Open drain: only ever pulls low, the address pin stays an input
                data_pin_oe_n = ~i2c_data_drive_low; // [R02] [R03]
            end
            MODE_SPI3: begin
                // Turnaround after the command byte
                data_pin_out = tx_shift_reg[7];
                data_pin_oe_n = ~(spi_selected & first_byte_done_reg); // [R02]
            end
            MODE_SPI4: begin
                // Data pin stays an input; reply goes out on the second pin
                addr1_or_serial_out_pin_out = tx_shift_reg[7];
                addr1_or_serial_out_pin_oe_n = ~spi_selected; // [R02] [R03]
            end
        endcase
    end

    // Status pins and change interrupt
    logic [STATUS_WIDTH-1:0] status_now, status_reg, status_next;
    logic pending_reg, pending_next;
    logic status_changed;

    assign status_now = {jitter_cleaning_pll_locked, input_clock_present};
    assign status_changed = (status_now != status_reg);

    always_comb begin
        status_next = status_now;
        pending_next = pending_reg;
        if (status_irq_clear) begin
            pending_next = 1'b0;
        end
        // A change in the clearing cycle is kept
        if (status_changed) begin
            pending_next = 1'b1; // [R06]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            status_reg <= STATUS_RESET;
            pending_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            pending_reg <= pending_next;
        end
    end

    assign status_change_irq_n = ~pending_reg; // [R06]
    assign lock_lost_n = status_reg[4]; // [R10]
    assign input0_signal_lost_n = status_reg[0]; // [R11]
    assign input1_signal_lost_n = status_reg[1]; // [R11]
    assign input2_signal_lost_n = status_reg[2]; // [R11]
    assign input3_signal_lost_n = status_reg[3]; // [R12]

endmodule

`default_nettype wire

// File: src/pin_sync3.sv
// Three-stage synchroniser for levels from outside the clock domain.
// Output moves only when the second and third stages agree.
`default_nettype none

module pin_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg, stage2_reg, stage3_reg, out_reg;
    logic [WIDTH-1:0] stage1_next, stage2_next, stage3_next, out_next;

    always_comb begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
        stage3_next = stage2_reg;
        out_next = out_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
                out_next[i] = stage3_reg[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
            stage3_reg <= RESET_VALUE;
            out_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            stage3_reg <= stage3_next;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;

endmodule

`default_nettype wire

// File: verification/host_pins_checker.sv
// Checker for the host pin block, bound onto its top-level ports.
// Assumes synced pin levels settle within seven system clocks.
`default_nettype none
module host_pins_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Inputs of the block
    input wire logic interface_select,
    input wire logic addr0_or_select_n_pin,
    input wire logic device_reset_n,
    input wire logic output_disable,
    input wire logic spi_three_wire,
    input wire logic i2c_data_drive_low,
    input wire logic jitter_cleaning_pll_locked,
    input wire logic [3:0] input_clock_present,
    input wire logic status_irq_clear,
    // Outputs of the block
    input wire logic data_pin_oe_n,
    input wire logic addr1_or_serial_out_pin_oe_n,
    input wire logic status_change_irq_n,
    input wire logic lock_lost_n,
    input wire logic input0_signal_lost_n,
    input wire logic input1_signal_lost_n,
    input wire logic input2_signal_lost_n,
    input wire logic input3_signal_lost_n,
    input wire logic i2c_mode,
    input wire logic device_in_reset,
    input wire logic clock_outputs_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic calm;
    logic [4:0] st;
    logic [4:0] src;
    // Pin reset reaches the core a few clocks late, so calm needs the raw pin high too
    assign calm = device_reset_n && !device_in_reset;
    assign st = {lock_lost_n, input3_signal_lost_n, input2_signal_lost_n,
        input1_signal_lost_n, input0_signal_lost_n};
    assign src = {jitter_cleaning_pll_locked, input_clock_present};
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    mode_follow_a: assert property (
        (calm && $stable(interface_select))[*7] |-> i2c_mode == interface_select)
        else $error("mode differs from select pin");
    outputs_gate_a: assert property (
        (calm && $stable(output_disable))[*7] |-> clock_outputs_enable == !output_disable)
        else $error("clock enable wrong");
    pin_reset_a: assert property (
        !device_reset_n[*8] |-> device_in_reset && !clock_outputs_enable)
        else $error("pin reset not applied");
    status_copy_a: assert property (
        (calm && $stable(src))[*5] |-> st == src)
        else $error("status pins wrong");
    irq_raise_a: assert property (
        calm[*3] ##0 $changed(st) |=> !status_change_irq_n)
        else $error("interrupt not raised");
    irq_clear_a: assert property (
        (calm && $stable(st) && st == src)[*3] ##0 status_irq_clear |=> status_change_irq_n)
        else $error("interrupt not cleared");
    i2c_pins_a: assert property (
        interface_select[*8]
        |-> addr1_or_serial_out_pin_oe_n && data_pin_oe_n == !i2c_data_drive_low)
        else $error("i2c pin drive wrong");
    spi4_pins_a: assert property (
        (calm && !interface_select && !spi_three_wire)[*8]
        |-> data_pin_oe_n && addr1_or_serial_out_pin_oe_n == addr0_or_select_n_pin)
        else $error("4-wire pin drive wrong");
endmodule
`default_nettype wire

// File: verification/spi_host_model.sv
// Host controller model: serial clock, chip select and outgoing data.
// Assumes the bench resolves the shared pins and returns the reply line.
`default_nettype none
module spi_host_model (
    // Link pins
    output logic serial_clk,
    output logic select_n,
    output logic mosi,
    output logic mosi_en,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        serial_clk = 1'h0;
        select_n = 1'h1;
        mosi = 1'h0;
        mosi_en = 1'h0;
    end
    // Clock runs only inside a frame, 80 ns a bit; reply sampled just before each rise
    task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
        select_n = 1'h0;
        mosi_en = drive;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #40;
            rx[i] = miso;
            serial_clk = 1'h1;
            #40;
            serial_clk = 1'h0;
        end
        mosi_en = 1'h0;
    endtask
    task automatic end_frame();
        #40;
        select_n = 1'h1;
    endtask
endmodule
`default_nettype wire

// File: verification/test_host_serial_select_and_status_pins.sv
// Bench for the host pin block: straps, status pins, resets and SPI frames.
// Assumes the package, design, checker and host model are compiled first.
`default_nettype none
module test_host_serial_select_and_status_pins;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, serial_clk, interface_select, data_pin_in, data_pin_out, data_pin_oe_n;
    logic addr1_or_serial_out_pin_in, addr1_or_serial_out_pin_out, addr1_or_serial_out_pin_oe_n;
    logic addr0_or_select_n_pin, device_reset_n, output_disable, status_change_irq_n, lock_lost_n;
    logic input0_signal_lost_n, input1_signal_lost_n, input2_signal_lost_n, input3_signal_lost_n;
    logic spi_three_wire, i2c_data_drive_low, jitter_cleaning_pll_locked, status_irq_clear;
    logic i2c_mode, device_in_reset, clock_outputs_enable, rx_byte_valid, select_n, mosi, mosi_en;
    logic a0, a1, miso;
    logic [1:0] i2c_addr_bits;
    logic [3:0] input_clock_present, los_n;
    logic [7:0] rx_byte, tx_byte;
    logic [7:0] rxq[$];
    int miscompares = 0;
    int n_checks = 0;
    assign addr0_or_select_n_pin = interface_select ? a0 : select_n;
    // Released lines: pull-up on data and the a1 strap on the second pin in I2C, inverse of the last host bit in SPI
    assign data_pin_in = !data_pin_oe_n ? data_pin_out : mosi_en ? mosi : interface_select | ~mosi;
    assign addr1_or_serial_out_pin_in = !addr1_or_serial_out_pin_oe_n ?
        addr1_or_serial_out_pin_out : interface_select ? a1 : ~mosi;
    assign miso = spi_three_wire ? data_pin_in : addr1_or_serial_out_pin_in;
    assign los_n = {input3_signal_lost_n, input2_signal_lost_n, input1_signal_lost_n,
        input0_signal_lost_n};
    host_serial_select_and_status_pins uut (.*);
    spi_host_model host (.serial_clk, .select_n, .mosi, .mosi_en, .miso);
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (rx_byte_valid === 1'h1)
            rxq.push_back(rx_byte);
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic clear_irq();
        status_irq_clear = 1'h1;
        tick(1);
        status_irq_clear = 1'h0;
        tick(2);
    endtask
    // Odd offset keeps the link clock out of step with the system clock
    task automatic frame(input logic three, input logic [7:0] reply);
        logic [7:0] r;
        spi_three_wire = three;
        rxq.delete();
        tick(8);
        #13;
        host.xfer(8'ha5, 1'h1, r);
        host.xfer(8'h3c, !three, r);
        host.end_frame();
        tick(10);
        chk(r, reply);
        chk(rxq.size(), 8'h02);
        chk(rxq[0], 8'ha5);
        if (!three)
            chk(rxq[1], 8'h3c);
        $display("test spi frame done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {reset, interface_select, device_reset_n, jitter_cleaning_pll_locked} = 4'hf;
        {a0, a1, output_disable, spi_three_wire, i2c_data_drive_low, status_irq_clear} = 6'h00;
        input_clock_present = 4'hf;
        tx_byte = 8'h5a;
        tick(8);
        reset = 1'h0;
        tick(10);
        a1 = 1'h1;
        tick(8);
        chk(i2c_mode, 1'h1);
        chk(i2c_addr_bits, 2'h2);
        chk(addr1_or_serial_out_pin_oe_n, 1'h1);
        i2c_data_drive_low = 1'h1;
        tick(1);
        chk({data_pin_oe_n, data_pin_in}, 2'h0);
        {a0, a1, i2c_data_drive_low} = 3'h4;
        tick(8);
        chk(i2c_addr_bits, 2'h1);
        chk(data_pin_in, 1'h1);
        $display("test i2c pins done");
        clear_irq();
        chk(status_change_irq_n, 1'h1);
        for (int i = 0; i < 4; i++) begin
            input_clock_present = ~(4'h1 << i);
            tick(3);
            chk(los_n, input_clock_present);
            chk(status_change_irq_n, 1'h0);
            clear_irq();
            input_clock_present = 4'hf;
            tick(3);
            chk(status_change_irq_n, 1'h0);
            clear_irq();
        end
        jitter_cleaning_pll_locked = 1'h0;
        tick(3);
        chk(lock_lost_n, 1'h0);
        jitter_cleaning_pll_locked = 1'h1;
        tick(3);
        chk(lock_lost_n, 1'h1);
        clear_irq();
        chk(status_change_irq_n, 1'h1);
        $display("test status pins done");
        output_disable = 1'h1;
        tick(8);
        chk(clock_outputs_enable, 1'h0);
        output_disable = 1'h0;
        tick(8);
        chk(clock_outputs_enable, 1'h1);
        device_reset_n = 1'h0;
        tick(8);
        chk({device_in_reset, clock_outputs_enable}, 2'h2);
        device_reset_n = 1'h1;
        tick(10);
        chk({device_in_reset, clock_outputs_enable, lock_lost_n}, 3'h3);
        $display("test disable and reset done");
        interface_select = 1'h0;
        tick(8);
        chk(i2c_mode, 1'h0);
        // Reply hold is empty after the pin reset and is reloaded one byte ahead,
        // so only the second frame carries the core's reply byte
        frame(1'h0, 8'h00);
        frame(1'h1, tx_byte);
        wrap_up();
    end
    // Whole run needs about 3.3 us; six times that means a hang
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end
endmodule
bind host_serial_select_and_status_pins host_pins_checker guard (.*);
`default_nettype wire
